// ===== rtl/tw_pkg.sv
package tw_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 8;
   localparam int PRESCALE_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FORCE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PORT = 8'h18;

   // Field positions
   localparam int CTRL_WAVE_LSB = 0;
   localparam int CTRL_COM_LSB = 2;
   localparam int CTRL_RUN_BIT = 4;
   localparam int FORCE_BIT = 0;
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;
   localparam int PORT_VALUE_BIT = 0;
   localparam int PORT_DIR_BIT = 1;
   localparam int PORT_OCB_BIT = 2;
   localparam int PORT_PIN_BIT = 3;

   // Counter extremes and step
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
   localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;

   // Reset values
   localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
   localparam logic [CNT_W-1:0] COMPARE_RST = 8'h00;
   localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 8'h00;
   localparam logic RUN_RST = 1'b0;
   localparam logic OCB_RST = 1'b0;

   typedef enum logic [1:0] {
      TW_NORMAL,
      TW_PHASE_CORRECT,
      TW_CTC,
      TW_FAST_PWM
   } tw_wave_t;

   typedef enum logic [1:0] {
      TW_COM_OFF,
      TW_COM_TOGGLE,
      TW_COM_CLEAR,
      TW_COM_SET
   } tw_com_t;

endpackage : tw_pkg

// ===== rtl/tw_prescaler.sv
`timescale 1ns/1ps
module tw_prescaler #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic [W-1:0] divisor,
   output logic tick
);

   logic [W-1:0] count;

   // One tick every divisor+1 clocks; divisor 0 ticks on every clock
   assign tick = enable & (count >= divisor);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
      end else if (!enable || tick) begin
         count <= '0;
      end else begin
         count <= count + W'(1);
      end
   end

endmodule : tw_prescaler

// ===== rtl/tw_top.sv
`timescale 1ns/1ps
module tw_top #(
   parameter int PRESCALE_W = tw_pkg::PRESCALE_W
) (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [tw_pkg::ADDR_W-1:0] PADDR,
   input wire logic [tw_pkg::DATA_W-1:0] PWDATA,
   output logic [tw_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic OC_PIN_IN,
   output logic OC_PIN_OUT,
   output logic OC_PIN_OE_B,
   output logic OVERFLOW_FLAG,
   output logic COMPARE_MATCH_FLAG
);
   import tw_pkg::*;

   // Bus side
   logic bus_setup;
   logic bus_access;
   logic bus_write;
   logic addr_hit;
   logic [DATA_W-1:0] read_mux;
   logic [DATA_W-1:0] prdata;
   logic wr_ctrl;
   logic wr_force;
   logic wr_count;
   logic wr_compare;
   logic wr_flags;
   logic wr_prescale;
   logic wr_port;

   // Control
   tw_wave_t waveform_mode_select;
   tw_com_t compare_output_mode;
   logic run;
   logic [PRESCALE_W-1:0] prescale;
   logic port_value;
   logic output_pin_direction_bit;

   // Timer state
   logic tick;
   logic [CNT_W-1:0] counter_value;
   logic [CNT_W-1:0] next_counter_value;
   logic [CNT_W-1:0] compare_buffer;
   logic [CNT_W-1:0] compare_value;
   logic match_block;
   logic pwm_mode;
   logic at_max;
   logic cmp_equal;
   logic match;
   logic leaves_max;
   logic bottom_event;
   logic force_event;
   logic overflow_flag;
   logic compare_match_flag;
   logic ovf_set;
   logic ovf_clear;
   logic cmp_set;
   logic cmp_clear;
   logic compare_output_bit;
   logic next_compare_output_bit;

   assign bus_setup = PSEL & ~PENABLE;
   assign bus_access = PSEL & PENABLE;
   assign bus_write = bus_access & PWRITE & addr_hit;

   assign wr_ctrl = bus_write & (PADDR == OFS_CTRL);
   assign wr_force = bus_write & (PADDR == OFS_FORCE);
   assign wr_count = bus_write & (PADDR == OFS_COUNT);
   assign wr_compare = bus_write & (PADDR == OFS_COMPARE);
   assign wr_flags = bus_write & (PADDR == OFS_FLAGS);
   assign wr_prescale = bus_write & (PADDR == OFS_PRESCALE);
   assign wr_port = bus_write & (PADDR == OFS_PORT);

   // Zero wait states; an unmapped address answers with an error
   assign PREADY = bus_access;
   assign PSLVERR = bus_access & ~addr_hit;
   assign PRDATA = prdata;

   always_comb begin
      read_mux = '0;
      addr_hit = 1'b1;
      if (PADDR == OFS_CTRL) begin
         read_mux[CTRL_WAVE_LSB +: 2] = waveform_mode_select;
         read_mux[CTRL_COM_LSB +: 2] = compare_output_mode;
         read_mux[CTRL_RUN_BIT] = run;
      end else if (PADDR == OFS_FORCE) begin
         read_mux = '0;
      end else if (PADDR == OFS_COUNT) begin
         read_mux[CNT_W-1:0] = counter_value;
      end else if (PADDR == OFS_COMPARE) begin
         // Software sees what it wrote, the buffer in PWM modes
         read_mux[CNT_W-1:0] = compare_buffer;
      end else if (PADDR == OFS_FLAGS) begin
         read_mux[FLAG_OVF_BIT] = overflow_flag;
         read_mux[FLAG_CMP_BIT] = compare_match_flag;
      end else if (PADDR == OFS_PRESCALE) begin
         read_mux[PRESCALE_W-1:0] = prescale;
      end else if (PADDR == OFS_PORT) begin
         read_mux[PORT_VALUE_BIT] = port_value;
         read_mux[PORT_DIR_BIT] = output_pin_direction_bit;
         read_mux[PORT_OCB_BIT] = compare_output_bit;
         read_mux[PORT_PIN_BIT] = OC_PIN_IN;
      end else begin
         addr_hit = 1'b0;
      end
   end

   // Read data is captured in the setup cycle and held through access
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         prdata <= '0;
      end else if (bus_setup && !PWRITE) begin
         prdata <= read_mux;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         waveform_mode_select <= TW_NORMAL;
         compare_output_mode <= TW_COM_OFF;
         run <= RUN_RST;
      end else if (wr_ctrl) begin
         waveform_mode_select <= tw_wave_t'(PWDATA[CTRL_WAVE_LSB +: 2]);
         compare_output_mode <= tw_com_t'(PWDATA[CTRL_COM_LSB +: 2]);
         run <= PWDATA[CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         prescale <= PRESCALE_W'(PRESCALE_RST);
      end else if (wr_prescale) begin
         prescale <= PWDATA[PRESCALE_W-1:0];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         port_value <= 1'b0;
         output_pin_direction_bit <= 1'b0;
      end else if (wr_port) begin
         port_value <= PWDATA[PORT_VALUE_BIT];
         output_pin_direction_bit <= PWDATA[PORT_DIR_BIT];
      end
   end

   tw_prescaler #(
      .W(PRESCALE_W)
   ) u_prescaler (
      .clk(CLOCK),
      .rst_b(RST_B),
      .enable(run),
      .divisor(prescale),
      .tick(tick)
   );

   assign pwm_mode = (waveform_mode_select == TW_FAST_PWM) |
                     (waveform_mode_select == TW_PHASE_CORRECT);
   assign at_max = (counter_value == CNT_MAX);
   assign cmp_equal = (counter_value == compare_value);
   // A counter write hides the match on the following timer tick
   assign match = tick & cmp_equal & ~match_block;
   // A counter write has priority over the step away from max
   assign leaves_max = tick & at_max & ~wr_count;
   assign bottom_event = leaves_max &
                         (waveform_mode_select == TW_FAST_PWM);
   assign force_event = wr_force & PWDATA[FORCE_BIT] & ~pwm_mode;

   // Next count follows the waveform mode and, in CTC, the compare match; a counter write wins
   always_comb begin
      next_counter_value = counter_value;
      if (wr_count) begin
         next_counter_value = PWDATA[CNT_W-1:0];
      end else if (tick) begin
         case (waveform_mode_select)
            TW_CTC: begin
               if (cmp_equal && !match_block) begin
                  next_counter_value = CNT_BOTTOM;
               end else begin
                  next_counter_value = counter_value + CNT_STEP;
               end
            end
            TW_FAST_PWM: begin
               if (at_max) begin
                  next_counter_value = CNT_BOTTOM;
               end else begin
                  next_counter_value = counter_value + CNT_STEP;
               end
            end
            default: begin
               next_counter_value = counter_value + CNT_STEP;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         counter_value <= COUNT_RST;
      end else begin
         counter_value <= next_counter_value;
      end
   end

   // Blocking holds until a tick consumes it, even with the timer stopped
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         match_block <= 1'b0;
      end else if (wr_count) begin
         match_block <= 1'b1;
      end else if (tick) begin
         match_block <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         compare_buffer <= COMPARE_RST;
      end else if (wr_compare) begin
         compare_buffer <= PWDATA[CNT_W-1:0];
      end
   end

   // Updating only at top keeps PWM pulses whole
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         compare_value <= COMPARE_RST;
      end else if (wr_compare && !pwm_mode) begin
         compare_value <= PWDATA[CNT_W-1:0];
      end else if (pwm_mode && tick && at_max) begin
         compare_value <= compare_buffer;
      end
   end

   // Max-to-bottom is the overflow point in every mode handled here
   assign ovf_set = leaves_max;
   assign ovf_clear = wr_flags & PWDATA[FLAG_OVF_BIT];
   assign cmp_set = match;
   assign cmp_clear = wr_flags & PWDATA[FLAG_CMP_BIT];

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         overflow_flag <= 1'b0;
      end else if (ovf_set) begin
         overflow_flag <= 1'b1;
      end else if (ovf_clear) begin
         overflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         compare_match_flag <= 1'b0;
      end else if (cmp_set) begin
         compare_match_flag <= 1'b1;
      end else if (cmp_clear) begin
         compare_match_flag <= 1'b0;
      end
   end

   assign OVERFLOW_FLAG = overflow_flag;
   assign COMPARE_MATCH_FLAG = compare_match_flag;

   // Output mode is only consulted at an event, so a new setting
   // shapes the bit from the next match, force or bottom event onward
   always_comb begin
      next_compare_output_bit = compare_output_bit;
      if (!pwm_mode && (match || force_event)) begin
         case (compare_output_mode)
            TW_COM_TOGGLE: begin
               next_compare_output_bit = ~compare_output_bit;
            end
            TW_COM_CLEAR: next_compare_output_bit = 1'b0;
            TW_COM_SET: next_compare_output_bit = 1'b1;
            default: next_compare_output_bit = compare_output_bit;
         endcase
      end else if (waveform_mode_select == TW_FAST_PWM) begin
         // Bottom wins over a match at max: constant level then
         if (bottom_event &&
             compare_output_mode == TW_COM_CLEAR) begin
            next_compare_output_bit = 1'b1;
         end else if (bottom_event &&
                      compare_output_mode == TW_COM_SET) begin
            next_compare_output_bit = 1'b0;
         end else if (match) begin
            case (compare_output_mode)
               TW_COM_TOGGLE: begin
                  next_compare_output_bit = ~compare_output_bit;
               end
               TW_COM_CLEAR: next_compare_output_bit = 1'b0;
               TW_COM_SET: next_compare_output_bit = 1'b1;
               default: next_compare_output_bit = compare_output_bit;
            endcase
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         compare_output_bit <= OCB_RST;
      end else begin
         compare_output_bit <= next_compare_output_bit;
      end
   end

   // Override takes effect at once; direction stays with software
   assign OC_PIN_OUT = (compare_output_mode != TW_COM_OFF) ?
                       compare_output_bit : port_value;
   assign OC_PIN_OE_B = ~output_pin_direction_bit;

endmodule : tw_top

// ===== verification/tw_load.sv
`timescale 1ns/1ps
module tw_load (
   input wire logic pin_out,
   input wire logic oe_b,
   output logic pin_in
);
   // Pull-down on the board: an undriven pin reads low, never the old level
   assign pin_in = oe_b ? 1'b0 : pin_out;
endmodule : tw_load

// ===== verification/tw_top_asserts.sv
`timescale 1ns/1ps
module tw_top_asserts (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [tw_pkg::ADDR_W-1:0] PADDR,
   input wire logic [tw_pkg::DATA_W-1:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic OC_PIN_OUT,
   input wire logic OC_PIN_OE_B,
   input wire logic OVERFLOW_FLAG,
   input wire logic COMPARE_MATCH_FLAG
);
   import tw_pkg::*;
   logic wr;
   logic [1:0] wave;
   logic [1:0] com;
   logic [1:0] port;
   assign wr = PSEL && PENABLE && PWRITE;
   // Shadows of the written fields, so pin checks need no internal probes
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         wave <= 2'h0;
         com <= 2'h0;
      end else if (wr && PADDR == OFS_CTRL) begin
         wave <= PWDATA[1:0];
         com <= PWDATA[3:2];
      end
   end
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         port <= 2'h0;
      end else if (wr && PADDR == OFS_PORT) begin
         port <= PWDATA[1:0];
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   property p_reset;
      $rose(RST_B) |-> !OC_PIN_OUT && OC_PIN_OE_B;
   endproperty
   a_reset: assert property (p_reset) else $error("pin not idle");
   property p_ready;
      PSEL && PENABLE |-> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_slverr;
      PSEL && PENABLE && PADDR > OFS_PORT |-> PSLVERR;
   endproperty
   a_slverr: assert property (p_slverr) else $error("no slave error");
   property p_ovf;
      $fell(OVERFLOW_FLAG) |-> $past(wr && PADDR == OFS_FLAGS && PWDATA[0]);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow lost");
   property p_cmp;
      $fell(COMPARE_MATCH_FLAG) |->
         $past(wr && PADDR == OFS_FLAGS && PWDATA[1]);
   endproperty
   a_cmp: assert property (p_cmp) else $error("match flag lost");
   property p_dir;
      OC_PIN_OE_B == !port[1];
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_port;
      com == 2'h0 |-> OC_PIN_OUT == port[0];
   endproperty
   a_port: assert property (p_port) else $error("port value lost");
   property p_force;
      wr && PADDR == OFS_FORCE && PWDATA[0] && !wave[0] && com[1]
         |=> OC_PIN_OUT == $past(com[0]);
   endproperty
   a_force: assert property (p_force) else $error("force ignored");
   c_force: cover property (wr && PADDR == OFS_FORCE);
   c_ovf: cover property ($rose(OVERFLOW_FLAG));
   c_cmp: cover property ($rose(COMPARE_MATCH_FLAG));
endmodule : tw_top_asserts
bind tw_top tw_top_asserts chk (.CLOCK, .RST_B, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PREADY, .PSLVERR, .OC_PIN_OUT, .OC_PIN_OE_B,
   .OVERFLOW_FLAG, .COMPARE_MATCH_FLAG);

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
   import tw_pkg::*;
   logic clock, rst_b, psel, penable, pwrite, pready, pslverr;
   logic pin_in, pin_out, oe_b, ovf, cmpf, errv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   int err_total, num_checks;
   always #12.5 clock = ~clock;
   tw_top dut (.CLOCK(clock), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .OC_PIN_IN(pin_in),
      .OC_PIN_OUT(pin_out), .OC_PIN_OE_B(oe_b), .OVERFLOW_FLAG(ovf),
      .COMPARE_MATCH_FLAG(cmpf));
   tw_load load (.pin_out(pin_out), .oe_b(oe_b), .pin_in(pin_in));
   task print_verdict;
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Later checks see settled outputs, not the launching edge
      @(negedge clock);
   endtask : apb
   task t_reset;
      apb(0, OFS_CTRL, 0);
      chk(rdv, 0, "ctrl");
      apb(0, OFS_PORT, 0);
      chk(rdv, 0, "port");
      chk({oe_b, pin_out}, 2'b10, "pin");
      apb(1, 8'h1c, 32'hffffffff);
      chk(errv, 1, "slverr");
      apb(0, 8'h1c, 0);
      chk({errv, rdv}, {1'b1, 32'h0}, "unmapped");
   endtask : t_reset
   task t_force;
      logic [1:0] cm [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3};
      logic fo [5] = '{1, 1, 1, 1, 0};
      logic ex [5] = '{1, 0, 1, 0, 0};
      apb(1, OFS_PORT, 32'h2);
      for (int i = 0; i < 5; i++) begin
         apb(1, OFS_CTRL, {28'h0, cm[i], 2'h0});
         if (fo[i]) apb(1, OFS_FORCE, 32'h1);
         apb(0, OFS_PORT, 0);
         chk({rdv[2], pin_in}, {ex[i], ex[i]}, "forced bit");
      end
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_PORT, 32'h3);
      chk(pin_in, 1, "port value");
      apb(1, OFS_PORT, 32'h1);
      chk(oe_b, 1, "direction");
   endtask : t_force
   task t_normal;
      int n;
      apb(1, OFS_PRESCALE, 32'h3f);
      apb(1, OFS_COUNT, 32'hff);
      apb(1, OFS_FLAGS, 32'h3);
      apb(1, OFS_CTRL, 32'h10);
      n = 0;
      while (ovf !== 1'b1 && n < 300) begin
         @(posedge clock);
         n++;
      end
      apb(0, OFS_COUNT, 0);
      chk(rdv, 0, "wrap at overflow");
      apb(1, OFS_FLAGS, 32'h1);
      chk(ovf, 0, "flag clear");
   endtask : t_normal
   task t_ctc_wrap;
      int n;
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_COMPARE, 32'h10);
      apb(1, OFS_COUNT, 32'h20);
      apb(1, OFS_FLAGS, 32'h3);
      apb(1, OFS_CTRL, 32'h12);
      // Compare below the count: run to ff, wrap, then match at 10
      n = 0;
      while (cmpf !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      chk(n, 242, "late match");
      chk({ovf, cmpf}, 2'b11, "wrap flags");
   endtask : t_ctc_wrap
   task t_buffer;
      int n;
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_COMPARE, 32'h80);
      apb(1, OFS_COUNT, 0);
      apb(1, OFS_FLAGS, 32'h3);
      apb(1, OFS_CTRL, 32'h13);
      // Goes to the buffer only: the first match stays at 80
      apb(1, OFS_COMPARE, 32'h10);
      n = 0;
      while (cmpf !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      chk(n, 127, "buffered compare");
      apb(1, OFS_FLAGS, 32'h2);
      // New value takes over at top, so the next match is at 10
      n = 0;
      while (cmpf !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      chk(n, 141, "taken at top");
   endtask : t_buffer
   task measure(output int hi, output int per);
      int n;
      n = 0;
      while (pin_in !== 1'b0 && n < 600) begin
         @(posedge clock);
         n++;
      end
      while (pin_in !== 1'b1 && n < 1200) begin
         @(posedge clock);
         n++;
      end
      hi = 0;
      while (pin_in === 1'b1 && hi < 600) begin
         @(posedge clock);
         hi++;
      end
      per = hi;
      while (pin_in !== 1'b1 && per < 1200) begin
         @(posedge clock);
         per++;
      end
   endtask : measure
   task t_wave;
      logic [1:0] wv [6] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
      logic [1:0] cm [6] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h2};
      logic [7:0] cp [6] = '{8'h03, 8'h40, 8'h40, 8'h00, 8'h10, 8'hff};
      int eh [5] = '{4, 'h41, 'hbf, 1, 256};
      int ep [5] = '{8, 256, 256, 256, 512};
      // Clear-on-match at 3 never reaches max, so no overflow there
      logic [1:0] ef [5] = '{2'b01, 2'b11, 2'b11, 2'b11, 2'b11};
      int hi, per, lows;
      for (int i = 0; i < 6; i++) begin
         apb(1, OFS_CTRL, 0);
         apb(1, OFS_PRESCALE, 0);
         apb(1, OFS_COMPARE, {24'h0, cp[i]});
         apb(1, OFS_COUNT, 0);
         apb(1, OFS_PORT, 32'h2);
         apb(1, OFS_FLAGS, 32'h3);
         apb(1, OFS_CTRL, {27'h0, 1'b1, cm[i], wv[i]});
         if (i < 5) begin
            measure(hi, per);
            chk(hi, eh[i], "high time");
            chk(per, ep[i], "period");
            chk({ovf, cmpf}, ef[i], "flags");
         end else begin
            // Compare at top: bottom wins, so the level never drops
            repeat (300) @(posedge clock);
            lows = 0;
            repeat (300) begin
               @(posedge clock);
               if (pin_in !== 1'b1) lows++;
            end
            chk(lows, 0, "constant level");
         end
      end
   endtask : t_wave
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_total = 0;
      num_checks = 0;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      t_reset;
      t_force;
      t_normal;
      t_wave;
      t_ctc_wrap;
      t_buffer;
      print_verdict;
   end
   initial begin
      repeat (40000) @(posedge clock);
      err_total++;
      print_verdict;
   end
endmodule : tb
